// File: src/bst_pkg.sv
// Constants of the boot strap latch: offsets, bit positions, reset values.
// Assumes a single mclk domain and a plain address/strobe register port.
package bst_pkg;
    // =====================================================
    // Strap bit positions
    localparam int STRAP_N = 5;
    localparam int SB_LDO = 0;
    localparam int SB_BOOT = 1;
    localparam int SB_QUAL = 2;
    localparam int SB_LOG = 3;
    localparam int SB_SDIO = 4;
    // Pull direction while in reset: one is pull-up
    localparam logic [4:0] PULL_UP_MASK = 5'h1a;
    // =====================================================
    // Register map
    localparam logic [7:0] STATUS_OFF = 8'h00;
    localparam logic [7:0] CTRL_OFF = 8'h04;
    localparam logic [7:0] CFG_OFF = 8'h08;
    // Control fields
    localparam int CT_LDO_EN = 0;
    localparam int CT_LDO_VAL = 1;
    localparam int CT_SDIO_EN = 2;
    localparam int CT_SDIO_LO = 3;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // Effective configuration fields
    localparam int CF_LDO18 = 0;
    localparam int CF_FLASH = 1;
    localparam int CF_DLOAD = 2;
    localparam int CF_LOG = 3;
    localparam int CF_OUT_RISE = 4;
    localparam int CF_IN_RISE = 5;
    localparam int CFG_W = 6;
    localparam logic [4:0] PULL_OFF = 5'h00;
endpackage : bst_pkg

// File: src/bst_strap_if.sv
// Carrier between the strap capture and the register core.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface bst_strap_if;
    logic [4:0] strap;
    logic [4:0] fnOut;
    logic [4:0] fnOe;
    logic [4:0] fnIn;
    modport cap (output strap, input fnOut, input fnOe, output fnIn);
    modport core (input strap, output fnOut, output fnOe, input fnIn);
endinterface : bst_strap_if
`default_nettype wire

// File: src/bst_strap_capture.sv
// Strap pin synchronisers, reset-time latch, pulls and pin hand-over.
// Assumes mclk runs while reset_n is low so the latch can sample.
`timescale 1ns/1ps
`default_nettype none
module bst_strap_capture (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [4:0] pinIn,
    output logic [4:0] pinOut,
    output logic [4:0] pinOe,
    output logic [4:0] pullUpEn,
    output logic [4:0] pullDnEn,
    bst_strap_if.cap sif
);
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic [4:0] strap_q, strap_d;
    logic [4:0] pinOut_q, pinOut_d;
    logic [4:0] pinOe_q, pinOe_d;
    logic [4:0] pu_q, pu_d;
    logic [4:0] pd_q, pd_d;

    // =====================================================
    // Synchroniser and latch, no reset: they must run during reset
    always_ff @(posedge mclk) begin
        meta_q <= pinIn;
        sync_q <= meta_q;
    end

    always_comb begin
        // Last edge before release wins; held afterwards
        strap_d = !reset_n ? sync_q : strap_q;
    end

    always_ff @(posedge mclk) begin
        strap_q <= strap_d;
    end

    // =====================================================
    // Pulls and functional hand-over
    always_comb begin
        pu_d = bst_pkg::PULL_OFF;
        pd_d = bst_pkg::PULL_OFF;
        pinOut_d = sif.fnOut;
        pinOe_d = sif.fnOe;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pu_q <= bst_pkg::PULL_UP_MASK;
            pd_q <= ~bst_pkg::PULL_UP_MASK;
            pinOut_q <= 5'h00;
            pinOe_q <= 5'h00;
        end else begin
            pu_q <= pu_d;
            pd_q <= pd_d;
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
        end
    end

    assign pullUpEn = pu_q;
    assign pullDnEn = pd_q;
    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign sif.strap = strap_q;
    assign sif.fnIn = sync_q;

    // =====================================================
    property p_capture;
        @(posedge mclk) disable iff (!reset_n)
        $rose(reset_n) |-> strap_q == $past(sync_q);
    endproperty
    a_capture: assert property (p_capture)
        else $error("strap not taken from pins at release");

    property p_hold;
        @(posedge mclk) disable iff (!reset_n)
        $past(reset_n) |-> $stable(strap_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("strap bits changed after reset");

    property p_pull_off;
        @(posedge mclk) disable iff (!reset_n)
        $past(reset_n) |-> (pu_q == 5'h00 && pd_q == 5'h00);
    endproperty
    a_pull_off: assert property (p_pull_off)
        else $error("pulls still on after reset");

    property p_release;
        @(posedge mclk) disable iff (!reset_n)
        $past(reset_n) |-> pinOe_q == $past(sif.fnOe)
            && pinOut_q == $past(sif.fnOut);
    endproperty
    a_release: assert property (p_release)
        else $error("pins not following functional drive");
endmodule : bst_strap_capture
`default_nettype wire

// File: src/bst_latch.sv
// Boot strap latch top: strap capture, decode, override and registers.
// Assumes a plain register port on mclk; read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module bst_latch #(
    parameter int DATA_W = 32
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [DATA_W-1:0] rdata,
    input wire logic [4:0] pinIn,
    output logic [4:0] pinOut,
    output logic [4:0] pinOe,
    output logic [4:0] pullUpEn,
    output logic [4:0] pullDnEn,
    input wire logic [4:0] fnOut,
    input wire logic [4:0] fnOe,
    output logic [4:0] fnIn,
    output logic ldoSel18,
    output logic bootFlash,
    output logic bootDownload,
    output logic bootLogEn,
    output logic sdioInRise,
    output logic sdioOutRise
);
    // =====================================================
    // Elaboration check
    if (DATA_W < 8) begin : g_bad_width
        $error("DATA_W must be at least 8");
    end

    bst_strap_if sif ();

    bst_strap_capture u_cap (
        .mclk(mclk),
        .reset_n(reset_n),
        .pinIn(pinIn),
        .pinOut(pinOut),
        .pinOe(pinOe),
        .pullUpEn(pullUpEn),
        .pullDnEn(pullDnEn),
        .sif(sif)
    );

    logic [4:0] fnIn_q;
    logic [4:0] strap;
    logic [bst_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [bst_pkg::CFG_W-1:0] cfg_q, cfg_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] sdioSel;

    assign strap = sif.strap;
    assign sif.fnOut = fnOut;
    assign sif.fnOe = fnOe;

    always_ff @(posedge mclk) begin
        fnIn_q <= sif.fnIn;
    end
    assign fnIn = fnIn_q;

    // =====================================================
    // Control register, firmware override
    always_comb begin
        ctrl_d = ctrl_q;
        // Status offset falls through: writes there do nothing
        if (wrStb && addr == bst_pkg::CTRL_OFF) begin
            ctrl_d = wdata[bst_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= bst_pkg::CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // =====================================================
    // Decode; no reset so it tracks straps through reset
    always_comb begin
        cfg_d = '0;
        sdioSel = {strap[bst_pkg::SB_LOG], strap[bst_pkg::SB_SDIO]};
        if (ctrl_q[bst_pkg::CT_SDIO_EN]) begin
            sdioSel = ctrl_q[bst_pkg::CT_SDIO_LO +: 2];
        end
        cfg_d[bst_pkg::CF_LDO18] = ctrl_q[bst_pkg::CT_LDO_EN]
            ? ctrl_q[bst_pkg::CT_LDO_VAL]
            : strap[bst_pkg::SB_LDO];
        cfg_d[bst_pkg::CF_FLASH] = strap[bst_pkg::SB_BOOT];
        cfg_d[bst_pkg::CF_DLOAD] = !strap[bst_pkg::SB_BOOT]
            && !strap[bst_pkg::SB_QUAL];
        cfg_d[bst_pkg::CF_LOG] = strap[bst_pkg::SB_LOG];
        cfg_d[bst_pkg::CF_IN_RISE] = sdioSel[1];
        cfg_d[bst_pkg::CF_OUT_RISE] = sdioSel[0];
    end

    // Needs a few mclk edges inside reset to settle before release
    always_ff @(posedge mclk) begin
        cfg_q <= cfg_d;
    end

    assign ldoSel18 = cfg_q[bst_pkg::CF_LDO18];
    assign bootFlash = cfg_q[bst_pkg::CF_FLASH];
    assign bootDownload = cfg_q[bst_pkg::CF_DLOAD];
    assign bootLogEn = cfg_q[bst_pkg::CF_LOG];
    assign sdioInRise = cfg_q[bst_pkg::CF_IN_RISE];
    assign sdioOutRise = cfg_q[bst_pkg::CF_OUT_RISE];

    // =====================================================
    // Read path; zero outside a read and for unmapped offsets
    always_comb begin
        rdata_d = '0;
        if (rdStb) begin
            case (addr)
                bst_pkg::STATUS_OFF: rdata_d[4:0] = strap;
                bst_pkg::CTRL_OFF: rdata_d[bst_pkg::CTRL_W-1:0] = ctrl_q;
                bst_pkg::CFG_OFF: rdata_d[bst_pkg::CFG_W-1:0] = cfg_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    // =====================================================
    sequence s_status_read;
        rdStb && addr == bst_pkg::STATUS_OFF;
    endsequence

    property p_status;
        @(posedge mclk) disable iff (!reset_n)
        s_status_read |=> rdata_q[4:0] == strap && rdata_q[DATA_W-1:5] == '0;
    endproperty
    a_status: assert property (p_status)
        else $error("status read does not show strap bits");

    property p_ldo;
        @(posedge mclk) disable iff (!reset_n)
        !ctrl_q[bst_pkg::CT_LDO_EN] && $stable(ctrl_q)
            |=> ldoSel18 == $past(strap[bst_pkg::SB_LDO]);
    endproperty
    a_ldo: assert property (p_ldo)
        else $error("regulator select not from strap");

    property p_boot;
        @(posedge mclk) disable iff (!reset_n)
        1'b1 |=> bootFlash == $past(strap[bst_pkg::SB_BOOT])
            && bootDownload == ($past(strap[2:1]) == 2'h0)
            && bootLogEn == $past(strap[bst_pkg::SB_LOG]);
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot decode wrong");

    property p_sdio;
        @(posedge mclk) disable iff (!reset_n)
        !ctrl_q[bst_pkg::CT_SDIO_EN] |=> {sdioInRise, sdioOutRise}
            == {$past(strap[bst_pkg::SB_LOG]), $past(strap[bst_pkg::SB_SDIO])};
    endproperty
    a_sdio: assert property (p_sdio)
        else $error("sdio timing decode wrong");

    sequence s_override_write;
        wrStb && addr == bst_pkg::CTRL_OFF && wdata[bst_pkg::CT_LDO_EN];
    endsequence

    property p_override;
        @(posedge mclk) disable iff (!reset_n)
        s_override_write ##1 !wrStb |=> ldoSel18 == $past(wdata[1], 2);
    endproperty
    a_override: assert property (p_override)
        else $error("firmware override not applied");

    property p_ro;
        @(posedge mclk) disable iff (!reset_n)
        wrStb && addr == bst_pkg::STATUS_OFF |=> $stable(strap)
            && $stable(ctrl_q);
    endproperty
    a_ro: assert property (p_ro)
        else $error("status write changed state");

    property p_stable_after;
        @(posedge mclk) disable iff (!reset_n)
        $rose(reset_n) |-> bootFlash == strap[bst_pkg::SB_BOOT]
            && bootLogEn == strap[bst_pkg::SB_LOG];
    endproperty
    a_stable_after: assert property (p_stable_after)
        else $error("configuration not ready at release");

    // =====================================================
    // Override and read-bus checks
    property p_ctrl_write;
        @(posedge mclk) disable iff (!reset_n)
        wrStb && addr == bst_pkg::CTRL_OFF
            |=> ctrl_q == $past(wdata[bst_pkg::CTRL_W-1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not taken");

    property p_ldo_override;
        @(posedge mclk) disable iff (!reset_n)
        ctrl_q[bst_pkg::CT_LDO_EN]
            |=> ldoSel18 == $past(ctrl_q[bst_pkg::CT_LDO_VAL]);
    endproperty
    a_ldo_override: assert property (p_ldo_override)
        else $error("regulator override not applied");

    property p_sdio_override;
        @(posedge mclk) disable iff (!reset_n)
        ctrl_q[bst_pkg::CT_SDIO_EN] |=> {sdioInRise, sdioOutRise}
            == $past(ctrl_q[bst_pkg::CT_SDIO_LO +: 2]);
    endproperty
    a_sdio_override: assert property (p_sdio_override)
        else $error("sdio override not applied");

    // Stale read data could pass for a fresh status read
    property p_idle_read;
        @(posedge mclk) disable iff (!reset_n)
        !rdStb |=> rdata_q == '0;
    endproperty
    a_idle_read: assert property (p_idle_read)
        else $error("read data left standing after a read");
endmodule : bst_latch
`default_nettype wire

// File: bench/bst_pin_host.sv
// Far side of the strap pins: host GPIOs or resistors, plus the pin wire.
// Assumes the latch drives pinOut/pinOe and pull enables on mclk.
`timescale 1ns/1ps
`default_nettype none
module bst_pin_host (
    input wire logic mclk,
    input wire logic [4:0] strapVal,
    input wire logic hostOn,
    input wire logic ldoHigh,
    input wire logic [4:0] pinOut,
    input wire logic [4:0] pinOe,
    input wire logic [4:0] pullUpEn,
    input wire logic [4:0] pullDnEn,
    output logic [4:0] pinIn
);
    logic [4:0] drv;
    logic [4:0] lastQ = 5'h00;
    // =====================================================
    // Host drive; ldo strap low unless a test asks
    assign drv = {strapVal[4:1], strapVal[0] & ldoHigh};
    always_ff @(posedge mclk) begin
        lastQ <= pinIn;
    end
    // =====================================================
    // Wire level; a floating pin wanders, never holds
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (pinOe[i]) pinIn[i] = pinOut[i];
            else if (hostOn) pinIn[i] = drv[i];
            else if (pullUpEn[i]) pinIn[i] = 1'h1;
            else if (pullDnEn[i]) pinIn[i] = 1'h0;
            else pinIn[i] = ~lastQ[i];
        end
    end
endmodule : bst_pin_host
`default_nettype wire

// File: bench/bst_latch_bench.sv
// Self-checking bench of the boot strap latch.
// Assumes bst_pin_host resolves the pins; one mclk domain.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    nCompared++; \
    if ((g) !== (e)) begin \
        nMismatch++; \
        $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); \
    end \
end
module bst_latch_bench;
    typedef struct packed {
        logic [4:0] s;
        logic hostOn;
        logic ldoHigh;
    } bst_row_t;
    bst_row_t rows [6] = '{'{5'h00, 1'h1, 1'h0}, '{5'h12, 1'h1, 1'h0},
        '{5'h0a, 1'h1, 1'h0}, '{5'h1b, 1'h1, 1'h1},
        '{5'h00, 1'h0, 1'h0}, '{5'h04, 1'h1, 1'h0}};
    logic mclk = 1'h0;
    logic reset_n;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wrStb;
    logic rdStb;
    logic [4:0] pinIn;
    logic [4:0] pinOut;
    logic [4:0] pinOe;
    logic [4:0] pullUpEn;
    logic [4:0] pullDnEn;
    logic [4:0] fnOut;
    logic [4:0] fnOe;
    logic [4:0] fnIn;
    wire [5:0] cfgV;
    logic [4:0] strapVal;
    logic hostOn;
    logic ldoHigh;
    int nMismatch = 0;
    int nCompared = 0;
    always #5 mclk = ~mclk;
    bst_latch i_dut (.mclk(mclk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pullUpEn(pullUpEn), .pullDnEn(pullDnEn), .fnOut(fnOut),
        .fnOe(fnOe), .fnIn(fnIn), .ldoSel18(cfgV[0]),
        .bootFlash(cfgV[1]), .bootDownload(cfgV[2]), .bootLogEn(cfgV[3]),
        .sdioOutRise(cfgV[4]), .sdioInRise(cfgV[5]));
    bst_pin_host i_host (.mclk(mclk), .strapVal(strapVal),
        .hostOn(hostOn), .ldoHigh(ldoHigh), .pinOut(pinOut),
        .pinOe(pinOe), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn),
        .pinIn(pinIn));
    // =====================================================
    // Helpers
    function automatic logic [5:0] cfgOf(input logic [4:0] s);
        cfgOf = {s[3], s[4], s[3], ~s[1] & ~s[2], s[1], s[0]};
    endfunction : cfgOf
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'h1;
        @(posedge mclk);
        rdStb <= 1'h0;
        #1;
        d = rdata;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wrStb <= 1'h1;
        @(posedge mclk);
        wrStb <= 1'h0;
    endtask : wr
    task automatic wrap_up;
        $display("compared %0d mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // =====================================================
    // Hang guard
    initial begin
        #200000;
        nMismatch++;
        $display("[ERR] %0t run limit reached", $time);
        wrap_up();
    end
    // =====================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [4:0] s;
        // Async flops need a real falling edge, not a start at zero
        reset_n = 1'h1;
        #1;
        reset_n = 1'h0;
        {addr, wdata, wrStb, rdStb, fnOut, fnOe} = '0;
        {strapVal, hostOn, ldoHigh} = '0;
        for (int r = 0; r < 6; r++) begin
            s = rows[r].hostOn ? rows[r].s & {4'hf, rows[r].ldoHigh} : 5'h1a;
            @(posedge mclk);
            reset_n <= 1'h0;
            {strapVal, hostOn, ldoHigh} <= rows[r];
            repeat (10) @(posedge mclk);
            #1;
            `CHK({pullUpEn, pullDnEn, pinOe}, 15'h68a0)
            @(posedge mclk);
            reset_n <= 1'h1;
            @(posedge mclk);
            #1;
            `CHK({pullUpEn, pullDnEn}, 10'h000)
            `CHK(cfgV, cfgOf(s))
            rd(bst_pkg::STATUS_OFF, d);
            `CHK(d, {27'h0, s})
            rd(bst_pkg::CFG_OFF, d);
            `CHK(d, {26'h0, cfgOf(s)})
            $display("row %0d done", r);
        end
        // Pins move after boot; straps stay
        @(posedge mclk);
        strapVal <= ~strapVal;
        ldoHigh <= 1'h1;
        repeat (6) @(posedge mclk);
        wr(bst_pkg::STATUS_OFF, 32'hffffffff);
        wr(bst_pkg::CFG_OFF, 32'hffffffff);
        rd(bst_pkg::STATUS_OFF, d);
        `CHK(d, {27'h0, s})
        `CHK(cfgV, cfgOf(s))
        rd(8'h40, d);
        `CHK(d, 32'h0)
        $display("hold test done");
        // Firmware override, then enables dropped
        wr(bst_pkg::CTRL_OFF, 32'h1f);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(cfgV, cfgOf(s) | 6'h31)
        wr(bst_pkg::CTRL_OFF, 32'h02);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(cfgV, cfgOf(s))
        rd(bst_pkg::CTRL_OFF, d);
        `CHK(d, 32'h02)
        $display("override test done");
        // Pins handed to functional logic
        @(posedge mclk);
        hostOn <= 1'h0;
        fnOe <= 5'h1f;
        fnOut <= 5'h15;
        @(posedge mclk);
        #1;
        `CHK({pinOe, pinOut}, 10'h3f5)
        repeat (3) @(posedge mclk);
        #1;
        `CHK(fnIn, 5'h15)
        $display("pin hand-over test done");
        wrap_up();
    end
endmodule : bst_latch_bench
`default_nettype wire
